//--- dv/testbench.sv
// self-checking bench for the gate and flag block
// assumes: apb slave with one-cycle answer, far end model drives pins
`timescale 1ns/100ps
`include "tgx_consts.svh"
module testbench;
	import tgx_pkg::*;
	logic      pclk = 1'b0;
	logic      presetn = 1'b0;
	logic      psel = 1'b0;
	logic      penable = 1'b0;
	logic      pwrite = 1'b0;
	tgx_addr_t paddr = 12'h000;
	tgx_data_t pwdata = 32'h0000_0000;
	tgx_data_t prdata;
	logic      pready, pslverr, a, b, k1, k0, f1, f0, r1, r0, c1, c0;
	logic [1:0] m1, m0;
	tgx_data_t rdv;
	logic      erv;
	int        n_mismatch = 0;
	int        checks = 0;
	int        cyc = 0;

	always #25 pclk = ~pclk;

	tgx_far_end i_far (.pclk(pclk), .pin_a(a), .pin_b(b), .ack1(k1), .ack0(k0));
	tgx_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ext_input_a(a), .ext_input_b(b),
		.ext_input_a_vector_ack(k1), .int0_vector_ack(k0), .ext_ext_input_a_req_flag(f1),
		.ext_int0_req_flag(f0), .tmr1_run_en(r1), .tmr0_run_en(r0), .tmr1_count_sel(c1),
		.tmr1_mode_sel(m1), .tmr0_count_sel(c0), .tmr0_mode_sel(m0));

	// ****
	// helpers
	// ****
	task finish_test;
		$display("mismatches %0d checks %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : finish_test

	task chk(input tgx_data_t got, input tgx_data_t exp);
		checks++;
		if (got !== exp) begin
			$display("wrong value t=%0t got %h exp %h", $time, got, exp);
			n_mismatch++;
		end
	endtask : chk

	task chk_bit(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask : chk_bit

	task wt(input int n);
		repeat (n) @(posedge pclk);
	endtask : wt

	task apb(input logic w, input tgx_addr_t ad, input tgx_data_t d);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= ad;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdv = prdata;
		erv = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task rd(input tgx_addr_t ad, input tgx_data_t exp);
		apb(1'b0, ad, 32'h0000_0000);
		chk(rdv, exp);
	endtask : rd

	task wr(input tgx_addr_t ad, input tgx_data_t d);
		apb(1'b1, ad, d);
	endtask : wr

	// ****
	// scenarios
	// ****
	task reg_test;
		tgx_data_t v;
		rd(`TGX_ADDR_TMC, 32'h0000_0000);
		for (int i = 0; i < 2; i++) begin
			v = i ? 32'h0000_005A : 32'h0000_00A5;
			wr(`TGX_ADDR_TMC, v);
			rd(`TGX_ADDR_TMC, v);
			chk({26'h0, c1, m1, c0, m0}, {26'h0, v[6:4], v[2:0]});
		end
		rd(12'h004, 32'h0000_0000);
		chk_bit(erv, 1'b1);
	endtask : reg_test

	task gate_test;
		wr(`TGX_ADDR_CFG, 32'h0000_0000);
		wr(`TGX_ADDR_TMC, 32'h0000_0000);
		wr(`TGX_ADDR_CTRL, 32'h0000_0040);
		wt(2);
		chk_bit(r1, 1'b1);
		i_far.set_pin(1, 1'b0);
		wt(8);
		chk_bit(r1, 1'b1);
		wr(`TGX_ADDR_TMC, 32'h0000_0080);
		wt(2);
		chk_bit(r1, 1'b1);
		i_far.set_pin(1, 1'b1);
		wt(8);
		chk_bit(r1, 1'b0);
		wr(`TGX_ADDR_CFG, 32'h0000_0002);
		wt(2);
		chk_bit(r1, 1'b1);
		rd(`TGX_ADDR_STAT, 32'h0000_000B);
		wr(`TGX_ADDR_CTRL, 32'h0000_0010);
		wt(2);
		chk_bit(r1, 1'b0);
		chk_bit(r0, 1'b1);
	endtask : gate_test

	task level_test;
		wr(`TGX_ADDR_CFG, 32'h0000_0000);
		wr(`TGX_ADDR_CTRL, 32'h0000_0000);
		wt(2);
		chk_bit(f1, 1'b0);
		i_far.set_pin(1, 1'b0);
		wt(8);
		chk_bit(f1, 1'b1);
		i_far.ack(1);
		wt(2);
		chk_bit(f1, 1'b1);
		i_far.set_pin(1, 1'b1);
		wt(8);
		wr(`TGX_ADDR_CTRL, 32'h0000_0000);
		wt(1);
		chk_bit(f1, 1'b0);
	endtask : level_test

	task edge_test;
		tgx_data_t t;
		for (int i = 0; i < 2; i++) begin
			t = i ? 32'h0000_0004 : 32'h0000_0001;
			wr(`TGX_ADDR_CTRL, t);
			wt(8);
			chk_bit(i ? f1 : f0, 1'b0);
			i_far.set_pin(i, 1'b0);
			wt(8);
			chk_bit(i ? f1 : f0, 1'b1);
			i_far.ack(i);
			wt(2);
			chk_bit(i ? f1 : f0, 1'b0);
			i_far.set_pin(i, 1'b1);
			wt(8);
			i_far.set_pin(i, 1'b0);
			wt(8);
			wr(`TGX_ADDR_CTRL, t);
			rd(`TGX_ADDR_CTRL, t);
			i_far.set_pin(i, 1'b1);
			wt(8);
		end
	endtask : edge_test

	// ****
	// main sequence and timeout
	// ****
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			finish_test;
		end
	end

	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		reg_test;
		gate_test;
		level_test;
		edge_test;
		finish_test;
	end
endmodule : testbench

//--- dv/tgx_far_end.sv
// far end model: interrupt pins and cpu vector acknowledges
// assumes: driven by testbench tasks on rising pclk edges
`timescale 1ns/100ps
module tgx_far_end (
	// clock
	input  wire logic pclk,
	// pins and acknowledges
	output logic      pin_a,
	output logic      pin_b,
	output logic      ack1,
	output logic      ack0
);
	initial begin
		pin_a = 1'b1;
		pin_b = 1'b1;
		ack1  = 1'b0;
		ack0  = 1'b0;
	end

	// ****
	// pin level, index 1 selects input a
	// ****
	task set_pin(input int i, input logic v);
		@(posedge pclk);
		if (i == 1) pin_a <= v;
		else pin_b <= v;
	endtask : set_pin

	task ack(input int i);
		@(posedge pclk);
		if (i == 1) ack1 <= 1'b1;
		else ack0 <= 1'b1;
		@(posedge pclk);
		ack1 <= 1'b0;
		ack0 <= 1'b0;
	endtask : ack
endmodule : tgx_far_end

//--- rtl/tgx_consts.svh
// register indices, byte addresses, field positions and reset values
// assumes: included by bare name from the package and the testbench
`ifndef TGX_CONSTS_SVH
`define TGX_CONSTS_SVH

// ***************************************************************
// register indices (byte address = 4 * index)
// ***************************************************************
`define TGX_IDX_CTRL       12'h088
`define TGX_IDX_TMC        12'h089
`define TGX_IDX_CFG        12'h090
`define TGX_IDX_STAT       12'h091
`define TGX_ADDR_CTRL      ((`TGX_IDX_CTRL) << 2)
`define TGX_ADDR_TMC       ((`TGX_IDX_TMC) << 2)
`define TGX_ADDR_CFG       ((`TGX_IDX_CFG) << 2)
`define TGX_ADDR_STAT      ((`TGX_IDX_STAT) << 2)

// ***************************************************************
// control register fields
// ***************************************************************
`define TGX_CTRL_RUN1      6
`define TGX_CTRL_RUN0      4
`define TGX_CTRL_FLAG1     3
`define TGX_CTRL_TYPE1     2
`define TGX_CTRL_FLAG0     1
`define TGX_CTRL_TYPE0     0

// ***************************************************************
// timer mode register fields
// ***************************************************************
`define TGX_TMC_TMR1_GATE_CTL      7
`define TGX_TMC_CSEL1      6
`define TGX_TMC_MODE1_HI   5
`define TGX_TMC_MODE1_LO   4
`define TGX_TMC_TMR0_GATE_CTL      3
`define TGX_TMC_CSEL0      2
`define TGX_TMC_MODE0_HI   1
`define TGX_TMC_MODE0_LO   0
`define TGX_TMC_RESET      8'h00

// ***************************************************************
// config and status fields
// ***************************************************************
`define TGX_CFG_POL1       1
`define TGX_CFG_POL0       0
`define TGX_STAT_EN1       3
`define TGX_STAT_EN0       2
`define TGX_STAT_LVL1      1
`define TGX_STAT_LVL0      0
`define TGX_DATA_ZERO      32'h0000_0000
`define TGX_PIN_IDLE       1'b1

`endif

//--- rtl/tgx_pkg.sv
// types shared by the gate and interrupt flag block
// assumes: tgx_consts.svh is on the include path
package tgx_pkg;
	`include "tgx_consts.svh"

	typedef logic [11:0] tgx_addr_t;
	typedef logic [31:0] tgx_data_t;

	// input filter state
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic level;
	} tgx_sync_t;

	// top level state
	typedef struct packed {
		logic       run1;
		logic       run0;
		logic       flag1;
		logic       type1;
		logic       flag0;
		logic       type0;
		logic [7:0] tmc;
		logic       pol1;
		logic       pol0;
		logic       act1_d;
		logic       act0_d;
		logic       en1;
		logic       en0;
		logic       pready;
		logic       pslverr;
		tgx_data_t  prdata;
	} tgx_state_t;
endpackage : tgx_pkg

//--- rtl/tgx_sync.sv
// three stage synchroniser with agreement filter for one pin
// assumes: pin is asynchronous to pclk; output is a registered level
`timescale 1ns/100ps
module tgx_sync #(
	parameter logic RESET_LEVEL = 1'b1
) (
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// pin and filtered level
	input  wire logic pin,
	output logic      level
);
	import tgx_pkg::*;

	tgx_sync_t st_r;
	tgx_sync_t st_nxt;

	always_comb begin
		st_nxt    = st_r;
		st_nxt.s1 = pin;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		// change counts once two later stages agree
		if (st_r.s2 == st_r.s3) begin
			st_nxt.level = st_r.s3;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= {4{RESET_LEVEL}};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign level = st_r.level;
endmodule : tgx_sync

//--- rtl/tgx_top.sv
// external interrupt request flags and timer run gating behind APB
// assumes: APB master on pclk; vector acks are one-cycle pulses on pclk
// Notes on behaviour
// - input 1 event of selected kind sets interrupt 1 request flag
// - software clears flag 1; vectoring clears it in edge mode
// - type select 0 means level triggered, 1 means edge triggered
// - polarity bit in config register sets active sense of input 1
// - gate 0: timer 1 runs whenever run bit is 1
// - gate 1: timer 1 runs only with run bit and input active
// - timer mode register layout gate, select, mode per timer, reset zero
// - writing 1 to run bit enables timer 1 subject to gate
`timescale 1ns/100ps
module tgx_top (
	// clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// apb slave
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire tgx_pkg::tgx_addr_t paddr,
	input  wire tgx_pkg::tgx_data_t pwdata,
	input  wire logic [3:0]       pstrb,
	output tgx_pkg::tgx_data_t    prdata,
	output logic                  pready,
	output logic                  pslverr,
	// external pins
	input  wire logic             ext_input_a,
	input  wire logic             ext_input_b,
	// cpu vector acknowledges
	input  wire logic             ext_input_a_vector_ack,
	input  wire logic             int0_vector_ack,
	// interrupt requests
	output logic                  ext_ext_input_a_req_flag,
	output logic                  ext_int0_req_flag,
	// timer controls
	output logic                  tmr1_run_en,
	output logic                  tmr0_run_en,
	output logic                  tmr1_count_sel,
	output logic [1:0]            tmr1_mode_sel,
	output logic                  tmr0_count_sel,
	output logic [1:0]            tmr0_mode_sel
);
	import tgx_pkg::*;

	// ***************************************************************
	// functions
	// ***************************************************************
	function automatic logic gate_run(input logic run, input logic gate, input logic act);
		gate_run = run & (~gate | act);
	endfunction : gate_run

	function automatic logic int_event(input logic edge_mode, input logic act, input logic act_d);
		int_event = edge_mode ? (act & ~act_d) : act;
	endfunction : int_event

	function automatic logic addr_hit(input tgx_addr_t a);
		addr_hit = (a == `TGX_ADDR_CTRL) || (a == `TGX_ADDR_TMC) ||
		           (a == `TGX_ADDR_CFG) || (a == `TGX_ADDR_STAT);
	endfunction : addr_hit

	// ***************************************************************
	// pin synchronisers
	// ***************************************************************
	logic lvl1;
	logic lvl0;

	tgx_sync #(.RESET_LEVEL(`TGX_PIN_IDLE)) u_sync1 (
		.pclk    (pclk),
		.presetn (presetn),
		.pin     (ext_input_a),
		.level   (lvl1)
	);

	tgx_sync #(.RESET_LEVEL(`TGX_PIN_IDLE)) u_sync0 (
		.pclk    (pclk),
		.presetn (presetn),
		.pin     (ext_input_b),
		.level   (lvl0)
	);

	// ***************************************************************
	// state
	// ***************************************************************
	tgx_state_t st_r;
	tgx_state_t st_nxt;
	logic       act1;
	logic       act0;
	logic       setup;
	logic       wr;
	logic       wr_ctrl;
	logic       wr_tmc;
	logic       wr_cfg;
	logic       ev1;
	logic       ev0;
	logic       gate_ok1;
	logic [7:0] wbyte;
	tgx_data_t  rdata;

	always_comb begin
		act1     = (lvl1 == st_r.pol1);
		act0     = (lvl0 == st_r.pol0);
		setup    = psel & ~penable;
		wr       = psel & penable & st_r.pready & pwrite & pstrb[0];
		wr_ctrl  = wr & (paddr == `TGX_ADDR_CTRL);
		wr_tmc   = wr & (paddr == `TGX_ADDR_TMC);
		wr_cfg   = wr & (paddr == `TGX_ADDR_CFG);
		wbyte    = pwdata[7:0];
		ev1      = int_event(st_r.type1, act1, st_r.act1_d);
		ev0      = int_event(st_r.type0, act0, st_r.act0_d);
		gate_ok1 = gate_run(st_r.run1, st_r.tmc[`TGX_TMC_TMR1_GATE_CTL], act1);
	end

	always_comb begin
		st_nxt = st_r;
		rdata  = `TGX_DATA_ZERO;
		if (wr_ctrl) begin
			st_nxt.run1  = wbyte[`TGX_CTRL_RUN1];
			st_nxt.run0  = wbyte[`TGX_CTRL_RUN0];
			st_nxt.type1 = wbyte[`TGX_CTRL_TYPE1];
			st_nxt.type0 = wbyte[`TGX_CTRL_TYPE0];
			st_nxt.flag1 = wbyte[`TGX_CTRL_FLAG1];
			st_nxt.flag0 = wbyte[`TGX_CTRL_FLAG0];
		end
		if (wr_tmc) begin
			st_nxt.tmc = wbyte;
		end
		if (wr_cfg) begin
			st_nxt.pol1 = wbyte[`TGX_CFG_POL1];
			st_nxt.pol0 = wbyte[`TGX_CFG_POL0];
		end
		if (ext_input_a_vector_ack && st_r.type1) begin
			st_nxt.flag1 = 1'b0;
		end
		if (int0_vector_ack && st_r.type0) begin
			st_nxt.flag0 = 1'b0;
		end
		if (ev1) begin
			st_nxt.flag1 = 1'b1;
		end
		if (ev0) begin
			st_nxt.flag0 = 1'b1;
		end
		st_nxt.act1_d = act1;
		st_nxt.act0_d = act0;
		st_nxt.en1 = gate_ok1;
		st_nxt.en0 = gate_run(st_r.run0, st_r.tmc[`TGX_TMC_TMR0_GATE_CTL], act0);
		// read mux, sampled in setup
		unique case (paddr)
			`TGX_ADDR_CTRL: begin
				rdata[`TGX_CTRL_RUN1]  = st_r.run1;
				rdata[`TGX_CTRL_RUN0]  = st_r.run0;
				rdata[`TGX_CTRL_FLAG1] = st_r.flag1;
				rdata[`TGX_CTRL_TYPE1] = st_r.type1;
				rdata[`TGX_CTRL_FLAG0] = st_r.flag0;
				rdata[`TGX_CTRL_TYPE0] = st_r.type0;
			end
			`TGX_ADDR_TMC: begin
				rdata[7:0] = st_r.tmc;
			end
			`TGX_ADDR_CFG: begin
				rdata[`TGX_CFG_POL1] = st_r.pol1;
				rdata[`TGX_CFG_POL0] = st_r.pol0;
			end
			`TGX_ADDR_STAT: begin
				rdata[`TGX_STAT_EN1]  = st_r.en1;
				rdata[`TGX_STAT_EN0]  = st_r.en0;
				rdata[`TGX_STAT_LVL1] = lvl1;
				rdata[`TGX_STAT_LVL0] = lvl0;
			end
			default: begin
				rdata = `TGX_DATA_ZERO;
			end
		endcase
		// zero wait: pready in the access cycle
		st_nxt.pready  = setup;
		st_nxt.pslverr = setup & ~addr_hit(paddr);
		st_nxt.prdata  = (setup & ~pwrite) ? rdata : `TGX_DATA_ZERO;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r      <= '0;
			st_r.tmc  <= `TGX_TMC_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ***************************************************************
	// outputs
	// ***************************************************************
	assign prdata            = st_r.prdata;
	assign pready            = st_r.pready;
	assign pslverr           = st_r.pslverr;
	assign ext_ext_input_a_req_flag = st_r.flag1;
	assign ext_int0_req_flag = st_r.flag0;
	assign tmr1_run_en       = st_r.en1;
	assign tmr0_run_en       = st_r.en0;
	assign tmr1_count_sel    = st_r.tmc[`TGX_TMC_CSEL1];
	assign tmr1_mode_sel     = st_r.tmc[`TGX_TMC_MODE1_HI:`TGX_TMC_MODE1_LO];
	assign tmr0_count_sel    = st_r.tmc[`TGX_TMC_CSEL0];
	assign tmr0_mode_sel     = st_r.tmc[`TGX_TMC_MODE0_HI:`TGX_TMC_MODE0_LO];

	// ***************************************************************
	// assertions
	// ***************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	edge_set_a: assert property (st_r.type1 && act1 && !st_r.act1_d |=> ext_ext_input_a_req_flag)
		else $error("edge on input 1 did not set flag 1");

	vec_clear_a: assert property (st_r.type1 && ext_input_a_vector_ack && !ev1 && !wr_ctrl |=> !ext_ext_input_a_req_flag)
		else $error("vector ack did not clear flag 1");

	level_set_a: assert property (!st_r.type1 && act1 && !wr_ctrl |=> ext_ext_input_a_req_flag ##0 $past(act1))
		else $error("active level did not set flag 1");

	pol_block_a: assert property (st_r.tmc[`TGX_TMC_TMR1_GATE_CTL] && (lvl1 != st_r.pol1) |=> !tmr1_run_en)
		else $error("inactive input 1 let gated timer 1 run");

	ungated_run_a: assert property (!st_r.tmc[`TGX_TMC_TMR1_GATE_CTL] && st_r.run1 |=> tmr1_run_en)
		else $error("ungated timer 1 not running");

	gated_run_a: assert property (tmr1_run_en |->
		$past(st_r.run1 && (!st_r.tmc[`TGX_TMC_TMR1_GATE_CTL] || (lvl1 == st_r.pol1))))
		else $error("timer 1 enabled without run and gate");

	mode_write_a: assert property (wr_tmc |=> (st_r.tmc == $past(wbyte)) && (tmr1_mode_sel == $past(wbyte[5:4])))
		else $error("timer mode register write lost");

	run_write_a: assert property (wr_ctrl && wbyte[`TGX_CTRL_RUN1] && !st_r.tmc[`TGX_TMC_TMR1_GATE_CTL] |=> ##1 tmr1_run_en)
		else $error("run write did not enable timer 1");

	int0_edge_a: assert property (st_r.type0 && act0 && !st_r.act0_d |=> ext_int0_req_flag)
		else $error("edge on input 0 did not set flag 0");

	apb_ready_a: assert property (setup |=> pready ##1 !pready)
		else $error("pready not a single access cycle");
endmodule : tgx_top
